// file: verilog/asirp_pkg.sv
// shared constants and types for the line bridge
package asirp_pkg;
    // ----------------------------------------------------------
    // clock and line timing
    // ----------------------------------------------------------
    localparam int CLK_NS = 40; // 25 MHz base clock
    localparam int HALF_BIT_NS = 3000; // manchester half bit
    localparam int TOL_NS = 400; // accepted edge jitter
    localparam int BREAK_MIN_NS = 9000; // break period, least
    localparam int BREAK_MAX_NS = 15000; // break period, most
    localparam int LOOP_MIN_NS = 4900; // base loopback, least
    localparam int LOOP_MAX_NS = 6500; // base loopback, most
    localparam int DLY_STEP_NS = 125; // one loopback code step
    localparam int DLY_CODES = 16; // 4-bit code
    localparam int HALF_CYC = HALF_BIT_NS / CLK_NS;
    localparam int FULL_CYC = 2 * HALF_CYC;
    localparam int TOL_CYC = TOL_NS / CLK_NS;
    localparam int BREAK_CYC = (BREAK_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int BASE_CYC = LOOP_MAX_NS / CLK_NS;
    localparam int DLY_MAX_CYC =
        ((DLY_CODES - 1) * DLY_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HIST_W = DLY_MAX_CYC + 1;
    // ----------------------------------------------------------
    // types
    // ----------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF, MODE_MASTER1, MODE_MASTER2, MODE_REPEAT
    } asirp_mode_t;
    typedef enum logic [1:0] {
        SYM_START, SYM_HALF, SYM_FULL, SYM_END
    } asirp_sym_t;
    localparam logic [3:0] REPEAT_CODE = 4'h5; // repeater ident
    localparam logic [3:0] MASTER1_TOP = 4'h4; // last master1 ident
    typedef struct packed {
        logic master_flag; // nonvolatile master enable
        logic [3:0] ident_select_code; // mode select code
        logic [3:0] loopback_delay_select; // extra loop delay
    } asirp_cfg_t;
endpackage

// file: verilog/asirp_fifo.sv
// small symbol fifo with valid/ready on both sides
`timescale 1ns/1ns
module asirp_fifo #(
    parameter int WIDTH = 2, // word width
    parameter int DEPTH = 4 // words held
) (
    input wire logic clk, // base clock
    input wire logic rst_n, // async reset, active low
    input wire logic flush, // drop all contents
    input wire logic in_valid, // write request
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word written
    output logic out_valid, // word available
    input wire logic out_ready, // reader takes word
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int AW = $clog2(DEPTH);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
        logic [AW-1:0] wp; // write index
        logic [AW-1:0] rp; // read index
        logic [AW:0] cnt; // words held
    } asirp_fifo_st_t;
    asirp_fifo_st_t r, n;
    logic push, pop; // handshakes completed

    assign in_ready = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next state; flush wins over both sides
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_data;
            n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
        end
        n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            n.wp = '0;
            n.rp = '0;
            n.cnt = '0;
        end
    end

    // register the state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // asirp_fifo

// file: verilog/asirp_phy.sv
// master/repeater line bridge: rx regeneration, loopback, power fail
// Notes on behaviour
// - receive output is regenerated manchester copy
// - reset input is active low
// - power fail output driven in master/repeater
// - rx active high master, low repeater
// - pf on rx only master1; loopback masters
// - telegrams checked, in-tolerance jitter removed
// - telegram error holds rx inactive break
// - transmit input passes straight to transmitter
// - no loopback: receiver off while transmitting
// - loopback: own signal read back to rx
// - extra loop delay is code times 125ns
// - break period lasts 9 to 15 us
// - mode chosen after reset from ident code
// - base loopback time 4.9 to 6.5 us
`timescale 1ns/1ns
module asirp_phy (
    input wire logic clk, // 25 MHz base clock
    input wire logic rst_n, // device reset pin, active low
    input asirp_pkg::asirp_cfg_t cfg_in, // nonvolatile settings
    input wire logic line_tx_in, // manchester from controller
    output logic line_tx_out, // to line transmitter
    input wire logic line_rx_in, // receiver comparator level
    output logic line_rx_en, // receiver enable
    input wire logic power_fail_in, // filtered pf comparator
    output logic line_rx_out, // regenerated manchester out
    output logic power_fail_out // line power fail
);
    // ----------------------------------------------------------
    // local types and helpers
    // ----------------------------------------------------------
    typedef enum logic [1:0] {RX_IDLE, RX_RUN, RX_DROP} asirp_rx_t;
    typedef enum logic [1:0] {RG_IDLE, RG_WAIT, RG_BREAK} asirp_rg_t;
    localparam int HW = asirp_pkg::HIST_W;
    localparam logic [7:0] HALF_LO =
        8'(asirp_pkg::HALF_CYC - asirp_pkg::TOL_CYC);
    localparam logic [7:0] HALF_HI =
        8'(asirp_pkg::HALF_CYC + asirp_pkg::TOL_CYC);
    localparam logic [7:0] FULL_LO =
        8'(asirp_pkg::FULL_CYC - asirp_pkg::TOL_CYC);
    localparam logic [7:0] FULL_HI =
        8'(asirp_pkg::FULL_CYC + asirp_pkg::TOL_CYC);

    // mode from master flag and ident code
    function automatic asirp_pkg::asirp_mode_t decode_mode(
        input logic flag, input logic [3:0] code);
        if (!flag)
            return asirp_pkg::MODE_OFF;
        else if (code <= asirp_pkg::MASTER1_TOP)
            return asirp_pkg::MODE_MASTER1;
        else if (code == asirp_pkg::REPEAT_CODE)
            return asirp_pkg::MODE_REPEAT;
        else
            return asirp_pkg::MODE_MASTER2;
    endfunction

    // delay code to whole base clock cycles, rounded up
    function automatic logic [5:0] dly_cycles(input logic [3:0] code);
        int ns;
        ns = int'(code) * asirp_pkg::DLY_STEP_NS;
        return 6'((ns + asirp_pkg::CLK_NS - 1) / asirp_pkg::CLK_NS);
    endfunction

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        logic cfg_done; // settings captured after reset
        asirp_pkg::asirp_mode_t mode; // operating mode
        logic [3:0] dly_code; // loopback delay code
        logic [HW-1:0] hist; // received level history
        logic rx_prev; // previous sampled level
        asirp_rx_t rx_st; // telegram checker state
        logic [7:0] ivl; // cycles since last edge
        asirp_rg_t rg_st; // regenerator state
        logic [7:0] rg_cnt; // regenerator wait count
        asirp_pkg::asirp_sym_t rg_sym; // symbol being played
        logic lvl; // regenerated level, 1 = active
        logic tx_prev; // previous transmit level
        logic [7:0] tx_busy; // transmit activity timer
        logic rx_en; // receiver enable
        logic rx_out; // receive pin
        logic pf_out; // power fail pin
    } asirp_st_t;
    asirp_st_t r, n;

    // comb signals shared with the fifo and the checks
    logic loop_on; // loopback active in this mode
    logic smp; // delayed received level
    logic edge_seen; // edge on the delayed level
    logic err; // telegram error this cycle
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    asirp_pkg::asirp_sym_t f_in_data, f_out_data;
    logic [1:0] f_out_raw; // fifo word before typing
    logic pop; // regenerator takes a symbol

    // ----------------------------------------------------------
    // transmit path
    // ----------------------------------------------------------
    // deliberately not registered: a flop here would add latency
    assign line_tx_out = line_tx_in;

    // ----------------------------------------------------------
    // jitter fifo between checker and regenerator
    // ----------------------------------------------------------
    asirp_fifo #(.WIDTH(2), .DEPTH(4)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(err),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_raw)
    );
    assign f_out_data = asirp_pkg::asirp_sym_t'(f_out_raw);
    assign f_out_ready = (r.rg_st == RG_IDLE);
    assign pop = f_out_valid && f_out_ready;
    assign loop_on = (r.mode == asirp_pkg::MODE_MASTER1) ||
                     (r.mode == asirp_pkg::MODE_MASTER2);
    assign smp = r.hist[dly_cycles(r.dly_code)];
    assign edge_seen = (smp != r.rx_prev);

    // ----------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------
    always_comb begin
        n = r;
        err = 1'b0;
        f_in_valid = 1'b0;
        f_in_data = asirp_pkg::SYM_START;
        // capture settings once, first edge after reset release
        if (!r.cfg_done) begin
            n.cfg_done = 1'b1;
            n.mode = decode_mode(cfg_in.master_flag,
                                 cfg_in.ident_select_code);
            n.dly_code = cfg_in.loopback_delay_select;
        end
        // transmit activity blanks the receiver without loopback
        n.tx_prev = line_tx_in;
        if (line_tx_in != r.tx_prev) begin
            n.tx_busy = FULL_HI;
        end else if (r.tx_busy != '0) begin
            n.tx_busy = r.tx_busy - 8'h01;
        end
        n.rx_en = r.cfg_done && (r.mode != asirp_pkg::MODE_OFF) &&
                  (loop_on || (n.tx_busy == '0));
        // history shift; disabled receiver reads as idle. gated by the
        // next enable so the very first transmit edge is blanked too
        n.hist = {r.hist[HW-2:0], line_rx_in && n.rx_en};
        n.rx_prev = smp;
        // telegram checker: classify each edge interval
        if (r.ivl != 8'hFF) begin
            n.ivl = r.ivl + 8'h01;
        end
        case (r.rx_st)
            RX_IDLE: begin
                if (edge_seen) begin
                    f_in_valid = 1'b1;
                    f_in_data = asirp_pkg::SYM_START;
                    n.ivl = 8'h01;
                    n.rx_st = RX_RUN;
                    err = !f_in_ready;
                end
            end
            RX_RUN: begin
                if (edge_seen) begin
                    n.ivl = 8'h01;
                    f_in_valid = 1'b1;
                    if (r.ivl >= HALF_LO && r.ivl <= HALF_HI) begin
                        f_in_data = asirp_pkg::SYM_HALF;
                    end else if (r.ivl >= FULL_LO && r.ivl <= FULL_HI) begin
                        f_in_data = asirp_pkg::SYM_FULL;
                    end else begin
                        f_in_valid = 1'b0;
                        err = 1'b1;
                    end
                    // a full fifo means the stream is out of step
                    if (f_in_valid && !f_in_ready) begin
                        err = 1'b1;
                    end
                end else if (r.ivl > FULL_HI) begin
                    f_in_valid = 1'b1;
                    f_in_data = asirp_pkg::SYM_END;
                    n.rx_st = RX_IDLE;
                    err = !f_in_ready;
                end
            end
            RX_DROP: begin
                // ignore the rest of a bad telegram until quiet
                if (edge_seen) begin
                    n.ivl = 8'h01;
                end else if (r.ivl > FULL_HI) begin
                    n.rx_st = RX_IDLE;
                end
            end
            default: n.rx_st = RX_IDLE;
        endcase
        if (err) begin
            f_in_valid = 1'b0;
            n.rx_st = RX_DROP;
        end
        // regenerator: replays symbols on an exact cycle grid
        case (r.rg_st)
            RG_IDLE: begin
                if (pop) begin
                    n.rg_sym = f_out_data;
                    n.rg_st = RG_WAIT;
                    // load is one short: the idle cycle counts too
                    case (f_out_data)
                        // start also pays the sample and push stages
                        // ahead of the fifo, so it loads two less
                        asirp_pkg::SYM_START:
                            n.rg_cnt = 8'(asirp_pkg::BASE_CYC - 3);
                        asirp_pkg::SYM_HALF:
                            n.rg_cnt = 8'(asirp_pkg::HALF_CYC - 1);
                        asirp_pkg::SYM_FULL:
                            n.rg_cnt = 8'(asirp_pkg::FULL_CYC - 1);
                        default: begin
                            n.lvl = 1'b0;
                            n.rg_st = RG_IDLE;
                        end
                    endcase
                end
            end
            RG_WAIT: begin
                n.rg_cnt = r.rg_cnt - 8'h01;
                if (r.rg_cnt <= 8'h01) begin
                    n.rg_st = RG_IDLE;
                    n.lvl = (r.rg_sym == asirp_pkg::SYM_START) ?
                            1'b1 : !r.lvl;
                end
            end
            RG_BREAK: begin
                n.lvl = 1'b0;
                n.rg_cnt = r.rg_cnt - 8'h01;
                if (r.rg_cnt <= 8'h01) begin
                    n.rg_st = RG_IDLE;
                end
            end
            default: n.rg_st = RG_IDLE;
        endcase
        if (err) begin
            n.rg_st = RG_BREAK;
            n.rg_cnt = 8'(asirp_pkg::BREAK_CYC);
            n.lvl = 1'b0;
        end
        // output pins with mode polarity and power fail
        n.pf_out = power_fail_in &&
                   (r.mode != asirp_pkg::MODE_OFF);
        case (r.mode)
            asirp_pkg::MODE_MASTER1:
                n.rx_out = n.lvl || power_fail_in;
            asirp_pkg::MODE_MASTER2: n.rx_out = n.lvl;
            asirp_pkg::MODE_REPEAT: n.rx_out = !n.lvl;
            default: n.rx_out = 1'b0;
        endcase
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign line_rx_out = r.rx_out;
    assign power_fail_out = r.pf_out;
    assign line_rx_en = r.rx_en;

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    AST_TX_THRU: assert property (@(posedge clk) disable iff (!rst_n)
        line_tx_out == line_tx_in) else $error("tx not passed");
    AST_PF_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        power_fail_in && r.mode != asirp_pkg::MODE_OFF |=>
        power_fail_out) else $error("power fail missed");
    AST_M1_PF: assert property (@(posedge clk) disable iff (!rst_n)
        r.mode == asirp_pkg::MODE_MASTER1 && power_fail_in |=>
        line_rx_out) else $error("master1 pf not on rx");
    AST_M2_NOPF: assert property (@(posedge clk) disable iff (!rst_n)
        r.mode == asirp_pkg::MODE_MASTER2 && !n.lvl |=>
        !line_rx_out) else $error("master2 rx not idle");
    AST_RPT_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        r.mode == asirp_pkg::MODE_REPEAT && !n.lvl |=>
        line_rx_out) else $error("repeater rx not idle high");
    AST_BREAK: assert property (@(posedge clk) disable iff (!rst_n)
        err |=> (!r.lvl && r.rg_st == RG_BREAK)[*8])
        else $error("break not held");
    AST_RX_BLANK: assert property (@(posedge clk) disable iff (!rst_n)
        r.mode == asirp_pkg::MODE_REPEAT &&
        line_tx_in != r.tx_prev |=> !line_rx_en)
        else $error("receiver on while sending");
    AST_LOOP_EN: assert property (@(posedge clk) disable iff (!rst_n)
        r.cfg_done && loop_on |=> line_rx_en)
        else $error("loopback receiver off");
    AST_START_LAT: assert property (@(posedge clk) disable iff (!rst_n)
        pop && f_out_data == asirp_pkg::SYM_START |->
        ##160 (r.lvl || r.rg_st == RG_BREAK))
        else $error("start edge late");
    AST_MODE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        r.cfg_done && r.mode == asirp_pkg::MODE_OFF |=>
        !line_rx_out && !power_fail_out && !line_rx_en)
        else $error("off mode drives pins");
endmodule // asirp_phy

// file: sim/asirp_ctrl_model.sv
// controller and line model facing the bridge
`timescale 1ns/1ns
module asirp_ctrl_model (
    input wire logic clk, // base clock
    input wire logic line_tx_out, // bridge transmitter drive
    output logic line_tx_in, // manchester stream to the bridge
    output logic line_rx_in // receiver comparator level
);
    // ----------------------------------------------------------
    // line: own transmitter plus another station
    // ----------------------------------------------------------
    logic foreign; // telegram from another station

    // both idle low outside frames, so no stale level lingers
    initial begin
        line_tx_in = 1'h0;
        foreign = 1'h0;
    end

    // the receiver hears everything on the pair, own drive too
    assign line_rx_in = line_tx_out | foreign;

    // one telegram: first edge, then a toggle after each gap;
    // an odd gap count leaves the line idle low again
    task automatic send(input logic on_line, input int gaps[$]);
        @(negedge clk);
        if (on_line) foreign = 1'h1;
        else line_tx_in = 1'h1;
        foreach (gaps[i]) begin
            repeat (gaps[i]) @(negedge clk);
            if (on_line) foreign = !foreign;
            else line_tx_in = !line_tx_in;
        end
    endtask
endmodule // asirp_ctrl_model

// file: sim/tb_top.sv
// testbench: modes, loopback timing, error break, repeater, power fail
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------------------------
    // signals and bookkeeping
    // ----------------------------------------------------------
    localparam int LIMIT = 40000; // cycle ceiling against a hang
    logic clk; // base clock
    logic rst_n; // reset, active low
    asirp_pkg::asirp_cfg_t cfg; // settings under test
    logic pf_in; // power fail comparator
    logic tx_in; // manchester from controller model
    logic tx_out; // transmitter drive
    logic rx_in; // receiver level
    logic rx_en; // receiver enable
    logic rx_out; // regenerated output
    logic pf_out; // power fail output
    int fail_count = 0; // mismatches
    int checked = 0; // comparisons made
    int cyc = 0; // clock cycles so far
    int txe[$]; // cycles of transmit edges
    int rxe[$]; // cycles of output edges
    logic rxl[$]; // output level after each edge
    logic last_tx; // previous transmit level
    logic last_rx; // previous output level
    int base_lat; // latency with no extra delay
    int brk; // start delay beyond base after an error
    logic in_rng; // result of a range test
    int nom[$] = {75, 150, 75, 75, 150}; // clean symbol gaps
    int jit[$] = {83, 142, 68, 75, 158}; // gaps within tolerance
    logic flg[4] = '{1'h0, 1'h1, 1'h1, 1'h1}; // master flag per mode
    logic [3:0] ids[4] = '{4'h9, 4'h2, 4'hB, 4'h5}; // off, m1, m2, rep
    logic pfrx[4] = '{1'h0, 1'h1, 1'h0, 1'h1}; // output under fail
    logic idl[4] = '{1'h0, 1'h0, 1'h0, 1'h1}; // idle output level

    asirp_phy uut (
        .clk(clk), .rst_n(rst_n), .cfg_in(cfg),
        .line_tx_in(tx_in), .line_tx_out(tx_out),
        .line_rx_in(rx_in), .line_rx_en(rx_en),
        .power_fail_in(pf_in), .line_rx_out(rx_out),
        .power_fail_out(pf_out)
    );

    asirp_ctrl_model ctrl (
        .clk(clk), .line_tx_out(tx_out),
        .line_tx_in(tx_in), .line_rx_in(rx_in)
    );

    // 25 MHz base clock
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------
    // monitors
    // ----------------------------------------------------------
    // inputs move on falling edges, so rising edges see them settled
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (tx_in !== last_tx) txe.push_back(cyc);
        last_tx = tx_in;
        check("tx_pass", tx_out, tx_in);
        if (cyc == LIMIT) begin
            fail_count++;
            end_sim();
        end
    end

    // outputs are registered, so falling edges see them settled
    always @(negedge clk) begin
        if (rx_out !== last_rx) begin
            rxe.push_back(cyc);
            rxl.push_back(rx_out);
        end
        last_rx = rx_out;
    end

    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // settings only take effect through a reset
    task automatic restart(input logic flag, input logic [3:0] id,
        input logic [3:0] dly);
        @(negedge clk);
        rst_n = 1'h0;
        cfg.loopback_delay_select = dly;
        cfg.ident_select_code = id;
        cfg.master_flag = flag;
        @(negedge clk);
        check("rst_rx", rx_out, 1'h0);
        check("rst_pf", pf_out, 1'h0);
        check("rst_en", rx_en, 1'h0);
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        txe.delete();
        rxe.delete();
        rxl.delete();
        last_rx = rx_out;
    endtask

    // master loopback; the first call must use code 0
    task automatic loop_run(input logic [3:0] id, input logic [3:0] dly);
        int extra;
        int lat;
        extra = (int'(dly) * asirp_pkg::DLY_STEP_NS + 39) / 40;
        restart(1'h1, id, dly);
        check("rx_en_master", rx_en, 1'h1);
        ctrl.send(1'h0, jit);
        repeat (300) @(negedge clk);
        check("loop_edges", rxe.size(), 6);
        if (rxe.size() == 6) begin
            lat = rxe[0] - txe[0];
            if (dly == 4'h0) base_lat = lat;
            check("loop_extra", lat - base_lat, extra);
            // transmit edges land half a 40 ns cycle before the edge
            // that counts them, so the true loopback is that much longer
            in_rng = (base_lat * 40 + 20) >= asirp_pkg::LOOP_MIN_NS &&
                     (base_lat * 40 + 20) <= asirp_pkg::LOOP_MAX_NS;
            check("loop_base", in_rng, 1'h1);
            check("rx_pol", rxl[0], 1'h1);
            for (int i = 1; i < 6; i++)
                check("spacing", rxe[i] - rxe[i-1], nom[i-1]);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        rst_n = 1'h0;
        cfg = '0;
        pf_in = 1'h0;
        last_tx = 1'h0;
        last_rx = 1'h0;
        base_lat = 0;
        // loopback across both master ident ranges and delay extremes
        loop_run(4'h6, 4'h0);
        loop_run(4'hF, 4'hF);
        loop_run(4'h4, 4'h7);
        loop_run(4'h0, 4'h1);
        // bad symbol gap: stays inactive, then recovers in time
        restart(1'h1, 4'h9, 4'h0);
        ctrl.send(1'h0, {40});
        // next telegram lands after the drop but inside the break
        repeat (200) @(negedge clk);
        check("err_quiet", rxe.size(), 0);
        ctrl.send(1'h0, jit);
        repeat (300) @(negedge clk);
        check("after_break", rxe.size(), 6);
        // its start must wait out the break, counted from the bad edge
        if (rxe.size() > 0 && txe.size() > 1) begin
            brk = rxe[0] - txe[1] - base_lat;
            in_rng = brk >= asirp_pkg::BREAK_CYC &&
                     brk <= asirp_pkg::BREAK_MAX_NS / asirp_pkg::CLK_NS;
            check("break_len", in_rng, 1'h1);
        end
        // repeater: receiver off while sending, low-active copy
        restart(1'h1, asirp_pkg::REPEAT_CODE, 4'h0);
        check("rep_idle", rx_out, 1'h1);
        fork
            ctrl.send(1'h0, nom);
            begin
                repeat (100) @(negedge clk);
                check("rep_rx_off", rx_en, 1'h0);
            end
        join
        repeat (165) @(negedge clk);
        check("rep_rx_back", rx_en, 1'h1);
        check("rep_no_echo", rxe.size(), 0);
        ctrl.send(1'h1, jit);
        repeat (300) @(negedge clk);
        check("rep_edges", rxe.size(), 6);
        if (rxe.size() > 0) check("rep_pol", rxl[0], 1'h0);
        // power fail in every mode
        for (int m = 0; m < 4; m++) begin
            restart(flg[m], ids[m], 4'h0);
            pf_in = 1'h1;
            repeat (3) @(negedge clk);
            check("pf_out", pf_out, flg[m]);
            check("pf_on_rx", rx_out, pfrx[m]);
            pf_in = 1'h0;
            repeat (3) @(negedge clk);
            check("pf_clear", pf_out, 1'h0);
            check("idle_rx", rx_out, idl[m]);
        end
        end_sim();
    end
endmodule // tb_top
